// ---- bench/sbt_host.sv ----
// host bus model driving the transmitter pins
`default_nettype none
module sbt_host
  import sbt_pkg::*;
(
  input wire logic ref_clk, // clock
  output logic cs_n, // select
  output logic rd_n, // read
  output logic wr_n, // write
  output logic [1:0] sel, // select lines
  output logic [sbt_pkg::SBT_W-1:0] bus, // bus level
  input wire logic [sbt_pkg::SBT_W-1:0] dout, // device data
  input wire logic doe // device drive
);
  timeunit 1ns;
  timeprecision 100ps;
  import sbt_pkg::*;
  sbt_byte_t wd = 8'h00;
  sbt_byte_t last = 8'h00;
  logic wdrv = 1'b0;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel = 2'h0;
  end
  // undriven bus toggles every cycle
  assign bus = doe ? dout : (wdrv ? wd : ~last);
  always @(posedge ref_clk) last <= bus;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [1:0] a, input sbt_byte_t d, input logic cs);
    sel = a;
    wd = d;
    wdrv = 1'b1;
    cs_n = cs;
    cyc(1);
    wr_n = 1'b0;
    cyc(8);
    wr_n = 1'b1;
    cyc(8);
    cs_n = 1'b1;
    wdrv = 1'b0;
    cyc(8);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic cs, input int n, output sbt_byte_t d, output logic oe);
    sel = a;
    cs_n = cs;
    cyc(1);
    rd_n = 1'b0;
    cyc(n);
    d = dout;
    oe = doe;
    rd_n = 1'b1;
    cs_n = 1'b1;
    cyc(8);
  endtask : rd
endmodule : sbt_host
`default_nettype wire

// ---- bench/sbt_props.sv ----
// port assertions for the serial byte transmitter
`default_nettype none
module sbt_props
  import sbt_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic reset_n, // device reset
  input wire logic chip_select_n, // select
  input wire logic read_n, // read strobe
  input wire logic [1:0] reg_sel, // select lines
  input wire logic base_clock, // rate clock
  input wire logic [sbt_pkg::SBT_W-1:0] data_out, // read data
  input wire logic data_oe, // drive enable
  input wire logic buffer_empty_irq, // irq
  input wire logic serial_out // serial data
);
  timeunit 1ns;
  timeprecision 100ps;
  import sbt_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence rd_held;
    (!chip_select_n && !read_n) [*8];
  endsequence
  sequence quiet;
    ($stable(base_clock) && reset_n) [*8];
  endsequence
  rd_drive_a: assert property (rd_held |-> data_oe) else $error("no drive on read");
  oe_cause_a: assert property ($rose(data_oe) |-> !chip_select_n && !read_n) else $error("drive without read");
  oe_drop_a: assert property (read_n [*8] |-> !data_oe) else $error("drive after read");
  cs_idle_a: assert property (chip_select_n [*8] |-> !data_oe) else $error("drive unselected");
  reset_clear_a: assert property (!reset_n [*8] |-> !buffer_empty_irq && !serial_out) else $error("reset kept");
  snap_zero_a: assert property ((!chip_select_n && !read_n && reg_sel == SBT_SEL_SNAP) [*8] |-> data_out == SBT_ZERO)
    else $error("snapshot select read nonzero");
  serial_hold_a: assert property (quiet |=> $stable(serial_out)) else $error("serial moved without tick");
  irq_hold_a: assert property (($stable(base_clock) && reset_n && chip_select_n) [*8] |=> $stable(buffer_empty_irq))
    else $error("irq moved without cause");
endmodule : sbt_props
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the serial byte transmitter
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sbt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_n = 1'b0;
  logic base_clock = 1'b0;
  logic base_run = 1'b1;
  logic last_bit = 1'b0;
  logic cs_n, rd_n, wr_n, data_oe, irq, serial_out, tx_ready, oe;
  logic [1:0] sel;
  sbt_byte_t bus, data_out, b;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  initial forever begin
    repeat (8) @(posedge ref_clk);
    #1;
    if (base_run) base_clock = ~base_clock;
  end
  always @(negedge base_clock) last_bit <= serial_out;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  sbt_host host_u (.ref_clk, .cs_n, .rd_n, .wr_n, .sel, .bus, .dout(data_out), .doe(data_oe));
  sbt_transmitter dut_u (.ref_clk, .rst, .reset_n, .chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n),
    .reg_sel(sel), .base_clock, .data_in(bus), .data_out, .data_oe, .buffer_empty_irq(irq), .serial_out, .tx_ready);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // waits for the irq state, bit7 came one sample earlier
  task automatic get_byte(input int d, output sbt_byte_t r);
    int k;
    for (k = 0; k < 9000 && irq !== 1'b1; k++) @(posedge ref_clk);
    r[7] = last_bit;
    for (k = 6; k >= 0; k--) begin
      repeat (k == 6 ? 1 : d) @(negedge base_clock);
      r[k] = serial_out;
    end
  endtask : get_byte
  task automatic t_send;
    host_u.wr(SBT_SEL_DIVISOR, 8'h00, 1'b0);
    host_u.wr(SBT_SEL_TXBYTE, 8'ha5, 1'b0);
    get_byte(1, b);
    chk("byte", 8'ha5, b);
    chk("irq", 8'h01, 8'(irq));
    host_u.rd(SBT_SEL_IRQCLR, 1'b0, 8, b, oe);
    chk("irq cleared", 8'h00, 8'(irq));
  endtask : t_send
  task automatic t_rate;
    host_u.wr(SBT_SEL_DIVISOR, 8'h02, 1'b0);
    // rate clock held so no load can slip in before the wait starts
    base_run = 1'b0;
    host_u.wr(SBT_SEL_TXBYTE, 8'h3c, 1'b0);
    host_u.wr(SBT_SEL_TXBYTE, 8'hc3, 1'b0);
    base_run = 1'b1;
    get_byte(2, b);
    chk("slow byte", 8'h3c, b);
    host_u.rd(SBT_SEL_IRQCLR, 1'b0, 8, b, oe);
    get_byte(2, b);
    chk("next byte", 8'hc3, b);
    host_u.rd(SBT_SEL_IRQCLR, 1'b0, 8, b, oe);
  endtask : t_rate
  task automatic t_cs;
    host_u.wr(SBT_SEL_TXBYTE, 8'hff, 1'b1);
    host_u.rd(SBT_SEL_DIVISOR, 1'b1, 8, b, oe);
    chk("oe unselected", 8'h00, 8'(oe));
    repeat (600) @(posedge ref_clk);
    #1;
    chk("no irq", 8'h00, 8'(irq));
  endtask : t_cs
  task automatic t_snap;
    host_u.wr(SBT_SEL_DIVISOR, 8'h05, 1'b0);
    host_u.rd(SBT_SEL_SNAP, 1'b0, 40, b, oe);
    chk("snap oe", 8'h01, 8'(oe));
    host_u.rd(SBT_RD_DIV_SNAP, 1'b0, 8, b, oe);
    chk("divider snapshot in 1..5", 8'h01, 8'(b >= 8'h01 && b <= 8'h05));
    host_u.rd(SBT_RD_SHF_SNAP, 1'b0, 8, b, oe);
    chk("shifter snapshot", SBT_ZERO, b);
  endtask : t_snap
  task automatic t_fifo;
    int i;
    host_u.wr(SBT_SEL_DIVISOR, 8'h02, 1'b0);
    base_run = 1'b0;
    for (i = 0; i < 9; i++) host_u.wr(SBT_SEL_TXBYTE, 8'(8'h81 + i), 1'b0);
    chk("fifo full", 8'h00, 8'(tx_ready));
    base_run = 1'b1;
    get_byte(2, b);
    chk("first queued", 8'h81, b);
    host_u.rd(SBT_SEL_IRQCLR, 1'b0, 8, b, oe);
    get_byte(2, b);
    chk("second queued", 8'h82, b);
    chk("room again", 8'h01, 8'(tx_ready));
  endtask : t_fifo
  task automatic t_reset;
    @(posedge ref_clk);
    #1;
    reset_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    chk("reset serial", 8'h00, 8'(serial_out));
    chk("reset irq", 8'h00, 8'(irq));
    reset_n = 1'b1;
  endtask : t_reset
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    reset_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    t_send();
    t_rate();
    t_cs();
    t_snap();
    t_fifo();
    t_reset();
    stop_test();
  end
endmodule : tb_top
bind sbt_transmitter sbt_props chk_u (.ref_clk, .rst, .reset_n, .chip_select_n, .read_n, .reg_sel, .base_clock,
  .data_out, .data_oe, .buffer_empty_irq, .serial_out);
`default_nettype wire

// ---- inc/sbt_pkg.sv ----
// shared constants for the serial byte transmitter
`default_nettype none
package sbt_pkg;
  localparam int SBT_W = 8;
  localparam int SBT_FIFO_DEPTH = 8;
  localparam logic [1:0] SBT_SEL_DIVISOR = 2'h0;
  localparam logic [1:0] SBT_SEL_TXBYTE = 2'h1;
  localparam logic [1:0] SBT_SEL_SNAP = 2'h2;
  localparam logic [1:0] SBT_SEL_IRQCLR = 2'h3;
  localparam logic [1:0] SBT_RD_DIV_SNAP = 2'h0;
  localparam logic [1:0] SBT_RD_SHF_SNAP = 2'h1;
  localparam logic [SBT_W-1:0] SBT_ZERO = 8'h00;
  localparam logic [SBT_W-1:0] SBT_CNT_ONE = 8'h01;
  localparam logic [SBT_W-1:0] SBT_DIVISOR_RST = 8'h00;
  localparam int SBT_MSB = SBT_W - 1;
  typedef logic [SBT_W-1:0] sbt_byte_t;
  typedef enum logic [2:0] {
    SBT_LOAD, SBT_IRQ, SBT_B3, SBT_B4, SBT_B5, SBT_B6, SBT_B7, SBT_LAST
  } sbt_state_t;
endpackage : sbt_pkg
`default_nettype wire

// ---- rtl/sbt_fifo.sv ----
// small valid/ready fifo holding bytes bound for the shifter
`default_nettype none
module sbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // clock
  input wire logic rst, // async reset, high
  input wire logic [WIDTH-1:0] in_data, // fill data
  input wire logic in_valid, // fill valid
  output logic in_ready, // room left
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // not empty
  input wire logic out_ready // drain accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= bump(wr_q);
      end
      if (pop) begin
        rd_q <= bump(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : sbt_fifo
`default_nettype wire

// ---- rtl/sbt_transmitter.sv ----
// host-programmed serial byte transmitter with rate divider and snapshots
`default_nettype none
module sbt_transmitter
  import sbt_pkg::*;
(
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rst, // async reset, high
  input wire logic reset_n, // device reset pin, low
  input wire logic chip_select_n, // chip select, low
  input wire logic read_n, // read strobe, low
  input wire logic write_n, // write strobe, low
  input wire logic [1:0] reg_sel, // register select
  input wire logic base_clock, // base clock pin
  input wire logic [sbt_pkg::SBT_W-1:0] data_in, // bus level in
  output logic [sbt_pkg::SBT_W-1:0] data_out, // bus drive value
  output logic data_oe, // bus drive enable
  output logic buffer_empty_irq, // buffer empty, high
  output logic serial_out, // serial data
  output logic tx_ready // fifo has room
);
  import sbt_pkg::*;

  // three-stage synchronisers for pins
  logic [2:0] csn_s_q;
  logic [2:0] rdn_s_q;
  logic [2:0] wrn_s_q;
  logic [2:0] rstn_s_q;
  logic [2:0] bclk_s_q;
  logic [1:0] sel_s1_q;
  logic [1:0] sel_s2_q;
  logic [1:0] sel_s3_q;
  sbt_byte_t din_s1_q;
  sbt_byte_t din_s2_q;
  sbt_byte_t din_s3_q;
  sbt_byte_t din_q;
  logic csn_q;
  logic rdn_q;
  logic wrn_q;
  logic rstn_q;
  logic bclk_q;
  logic [1:0] sel_q;

  function automatic logic settle(input logic cur, input logic [2:0] s);
    settle = (s[1] == s[2]) ? s[2] : cur;
  endfunction : settle

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csn_s_q <= 3'h7;
      rdn_s_q <= 3'h7;
      wrn_s_q <= 3'h7;
      rstn_s_q <= 3'h0;
      bclk_s_q <= 3'h0;
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
      sel_s3_q <= 2'h0;
      din_s1_q <= SBT_ZERO;
      din_s2_q <= SBT_ZERO;
      din_s3_q <= SBT_ZERO;
    end else begin
      csn_s_q <= {csn_s_q[1:0], chip_select_n};
      rdn_s_q <= {rdn_s_q[1:0], read_n};
      wrn_s_q <= {wrn_s_q[1:0], write_n};
      rstn_s_q <= {rstn_s_q[1:0], reset_n};
      bclk_s_q <= {bclk_s_q[1:0], base_clock};
      sel_s1_q <= reg_sel;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
    end
  end

  // data bus word counts once the last two stages agree
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      din_q <= SBT_ZERO;
    end else if (din_s2_q == din_s3_q) begin
      din_q <= din_s3_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csn_q <= 1'b1;
      rdn_q <= 1'b1;
      wrn_q <= 1'b1;
      rstn_q <= 1'b0;
      bclk_q <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      csn_q <= settle(csn_q, csn_s_q);
      rdn_q <= settle(rdn_q, rdn_s_q);
      wrn_q <= settle(wrn_q, wrn_s_q);
      rstn_q <= settle(rstn_q, rstn_s_q);
      bclk_q <= settle(bclk_q, bclk_s_q);
      if (sel_s2_q == sel_s3_q) begin
        sel_q <= sel_s3_q;
      end
    end
  end

  // write data tracks the bus while strobe low, stored at its rise
  sbt_byte_t wdata_q;
  logic wrn_d1_q;
  logic cs_active;
  logic wr_rise;
  logic rd_cs;

  assign cs_active = !csn_q;
  assign wr_rise = wrn_q && !wrn_d1_q && cs_active && rdn_q;
  assign rd_cs = !rdn_q && cs_active;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdata_q <= SBT_ZERO;
      wrn_d1_q <= 1'b1;
    end else begin
      wrn_d1_q <= wrn_q;
      if (!wrn_q) begin
        wdata_q <= din_q;
      end
    end
  end

  // divisor register
  sbt_byte_t divisor_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divisor_q <= SBT_DIVISOR_RST;
    end else if (wr_rise && sel_q == SBT_SEL_DIVISOR) begin
      divisor_q <= wdata_q;
    end
  end

  // transmit bytes queue behind the data register
  logic fifo_in_valid;
  logic fifo_in_ready;
  sbt_byte_t fifo_out_data;
  logic fifo_out_valid;
  logic fifo_pop;

  assign fifo_in_valid = wr_rise && sel_q == SBT_SEL_TXBYTE;

  sbt_fifo #(
    .WIDTH(SBT_W),
    .DEPTH(SBT_FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(rst),
    .in_data(wdata_q),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= fifo_in_ready;
    end
  end

  // rate divider on base clock rising edges
  logic bclk_d1_q;
  logic bclk_rise;
  sbt_byte_t count_q;
  logic tick;

  // the zero count lasts no time: the edge that would reach it presets
  // instead, so divisor n gives one tick per n edges (0 acts as 1)
  function automatic logic at_zero(input sbt_byte_t c);
    at_zero = (c == SBT_ZERO) || (c == SBT_CNT_ONE);
  endfunction : at_zero

  assign bclk_rise = bclk_q && !bclk_d1_q;
  assign tick = bclk_rise && at_zero(count_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bclk_d1_q <= 1'b0;
    end else begin
      bclk_d1_q <= bclk_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= SBT_ZERO;
    end else if (!rstn_q) begin
      count_q <= SBT_ZERO;
    end else if (bclk_rise) begin
      if (at_zero(count_q)) begin
        count_q <= divisor_q;
      end else begin
        count_q <= count_q - SBT_CNT_ONE;
      end
    end
  end

  // control machine and shifter
  sbt_state_t state_q;
  sbt_byte_t shift_q;
  logic loaded_q;

  assign fifo_pop = tick && state_q == SBT_LOAD && rstn_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= SBT_LOAD;
    end else if (!rstn_q) begin
      state_q <= SBT_LOAD;
    end else if (tick) begin
      case (state_q)
        SBT_LOAD: state_q <= SBT_IRQ;
        SBT_IRQ: state_q <= SBT_B3;
        SBT_B3: state_q <= SBT_B4;
        SBT_B4: state_q <= SBT_B5;
        SBT_B5: state_q <= SBT_B6;
        SBT_B6: state_q <= SBT_B7;
        SBT_B7: state_q <= SBT_LAST;
        SBT_LAST: state_q <= SBT_LOAD;
        default: state_q <= SBT_LOAD;
      endcase
    end
  end

  // an empty queue sends an idle-low byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= SBT_ZERO;
      loaded_q <= 1'b0;
    end else if (!rstn_q) begin
      shift_q <= SBT_ZERO;
      loaded_q <= 1'b0;
    end else if (tick) begin
      if (state_q == SBT_LOAD) begin
        shift_q <= fifo_out_valid ? fifo_out_data : SBT_ZERO;
        loaded_q <= fifo_out_valid;
      end else begin
        shift_q <= {shift_q[SBT_MSB-1:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b0;
    end else if (!rstn_q) begin
      serial_out <= 1'b0;
    end else if (tick) begin
      if (state_q == SBT_LOAD) begin
        serial_out <= fifo_out_valid ? fifo_out_data[SBT_MSB] : 1'b0;
      end else begin
        serial_out <= shift_q[SBT_MSB-1];
      end
    end
  end

  // buffer-empty interrupt; setting beats the clearing read
  logic irq_set;
  logic irq_clr;
  logic rd_cs_d1_q;
  assign irq_set = tick && state_q == SBT_IRQ && loaded_q;
  assign irq_clr = rd_cs && !rd_cs_d1_q && sel_q == SBT_SEL_IRQCLR;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_cs_d1_q <= 1'b0;
    end else begin
      rd_cs_d1_q <= rd_cs;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buffer_empty_irq <= 1'b0;
    end else if (!rstn_q) begin
      buffer_empty_irq <= 1'b0;
    end else if (irq_set) begin
      buffer_empty_irq <= 1'b1;
    end else if (irq_clr) begin
      buffer_empty_irq <= 1'b0;
    end
  end

  // diagnostic snapshots
  sbt_byte_t div_snap_q;
  sbt_byte_t shf_snap_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_snap_q <= SBT_ZERO;
      shf_snap_q <= SBT_ZERO;
    end else if (cs_active && sel_q == SBT_SEL_SNAP && bclk_q) begin
      div_snap_q <= count_q;
      shf_snap_q <= shift_q;
    end
  end

  // read path
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_out <= SBT_ZERO;
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_cs;
      case (sel_q)
        SBT_RD_DIV_SNAP: data_out <= div_snap_q;
        SBT_RD_SHF_SNAP: data_out <= shf_snap_q;
        default: data_out <= SBT_ZERO;
      endcase
    end
  end
endmodule : sbt_transmitter
`default_nettype wire
